// File: ssc_far.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_far (
    input wire logic clk,
    output logic [4:0] pins
);
    // lines rest high on their pull-ups between actions
    initial pins = 5'h1F;
    // move one line just after an edge
    task automatic set_line(input int idx, input logic val);
        @(posedge clk);
        pins[idx] <= val;
    endtask
    // low for len cycles, then back to idle
    task automatic pulse(input int idx, input int len);
        set_line(idx, 1'b0);
        repeat (len) @(posedge clk);
        pins[idx] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: ssc_pkg.sv
`default_nettype none
package ssc_pkg;

    // register byte addresses
    localparam logic [7:0] SSC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SSC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SSC_ADDR_SEQ_LAST = 8'h08;
    localparam logic [7:0] SSC_ADDR_EVT_DEST = 8'h0C;
    localparam logic [7:0] SSC_ADDR_STEP_BASE = 8'h40;

    // sequence table geometry
    localparam int SSC_NUM_STEPS = 16;
    localparam int SSC_IDX_W = 4;
    localparam int SSC_CODE_W = 4;

    // control register field positions
    localparam int SSC_CTRL_MODE_BIT = 0;
    localparam int SSC_CTRL_EN_BIT = 1;
    localparam int SSC_CTRL_SEL_BIT = 2;

    // step entry field positions
    localparam int SSC_STEP_CODE_LSB = 0;
    localparam int SSC_STEP_DEST_LSB = 4;

    // values after reset
    localparam logic [2:0] SSC_CTRL_RESET = 3'h0;
    localparam logic [3:0] SSC_SEQ_LAST_RESET = 4'h0;
    localparam logic [3:0] SSC_EVT_DEST_RESET = 4'h0;
    localparam logic [7:0] SSC_STEP_RESET = 8'h00;

    // control input lane positions in the synchroniser
    localparam int SSC_IN_W = 5;
    localparam int SSC_IN_START = 0;
    localparam int SSC_IN_STOP = 1;
    localparam int SSC_IN_HOLD = 2;
    localparam int SSC_IN_EVENT = 3;
    localparam int SSC_IN_TRIG = 4;

    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_RUN = 2'b01,
        SSC_HOLD = 2'b10
    } ssc_state_e;

    // software control settings
    typedef struct packed {
        logic start_is_branch;
        logic ctrl_en;
        logic seq_mode;
    } ssc_ctl_s;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ssc_req_s;

endpackage
`default_nettype wire

// File: ssc_props.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic ctl_start_n,
    input wire logic ctl_stop_n,
    input wire logic ctl_hold_n,
    input wire logic ctl_event_n,
    input wire logic [ssc_pkg::SSC_CODE_W-1:0] step_code,
    input wire logic [ssc_pkg::SSC_IDX_W-1:0] seq_step,
    input wire logic running,
    input wire logic held,
    input wire logic restart
);
    import ssc_pkg::*;
    logic [2:0] ctl_q;
    logic [3:0] evt_q;
    logic en, seq, br;
    assign {br, en, seq} = ctl_q;
    // shadow of software settings
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_q <= 3'h0;
            evt_q <= 4'h0;
        end
        else if (wr)
        begin
            if (addr == SSC_ADDR_CTRL)
                ctl_q <= wdata[2:0];
            if (addr == SSC_ADDR_EVT_DEST)
                evt_q <= wdata[3:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // line edges and states
    sequence s_start;
        en && !(seq && br) && $fell(ctl_start_n) && ctl_stop_n;
    endsequence
    sequence s_idle;
        !running && !held;
    endsequence
    sweep_start_a: assert property (s_start |-> ##[1:5]
        (running && restart && (!seq || seq_step == 4'h0))) else $error("start not taken");
    stop_ends_a: assert property (en && $fell(ctl_stop_n) |-> ##[1:5] s_idle)
        else $error("stop not taken");
    hold_freeze_a: assert property (en && running && $fell(ctl_hold_n) |-> ##[1:5] held)
        else $error("hold not taken");
    hold_resume_a: assert property (en && held && $rose(ctl_hold_n) |-> ##[1:5] running)
        else $error("resume not taken");
    held_step_a: assert property (held ##1 held |-> $stable(seq_step) && $stable(step_code))
        else $error("held step moved");
    event_jump_a: assert property (en && seq && running && $fell(ctl_event_n) |->
        ##[1:5] (restart && seq_step == evt_q)) else $error("event jump wrong");
    idle_code_a: assert property (s_idle ##1 s_idle |-> step_code == 4'h0)
        else $error("code not zero when idle");
    disabled_a: assert property (!en && !running && !held && $fell(ctl_start_n) |=>
        (!running)[*5])
        else $error("disabled line acted");
endmodule
bind ssc_top ssc_props u_props (.ref_clk, .resetn, .addr, .wdata, .wr, .ctl_start_n,
    .ctl_stop_n, .ctl_hold_n, .ctl_event_n, .step_code, .seq_step, .running, .held, .restart);
`default_nettype wire

// File: ssc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_sync #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] fall,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // two-flop synchroniser, idle lines read high (pulled up)
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge detection on the settled copy only
    assign level = sync_q;
    assign fall = prev_q & ~sync_q;
    assign rise = ~prev_q & sync_q;
endmodule
`default_nettype wire

// File: ssc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - sweep start line fall restarts sweep, ORed trigger
// - sweep stop line fall ends sweep
// - hold line fall freezes running sweep
// - hold line rise resumes held sweep
// - sequence mode: four inputs, selectable first
// - start selected: fall launches sequence step zero
// - branch selected: low at step end jumps
// - sequence stop line fall ends sequence
// - hold line fall pauses running sequence
// - hold line rise resumes paused sequence
// - event line fall jumps to destination step
// - drive configured code of current step
// - code bit0 least significant, zero in sweep
module ssc_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic ctl_start_n,
    input wire logic ctl_stop_n,
    input wire logic ctl_hold_n,
    input wire logic ctl_event_n,
    input wire logic external_trigger_input,
    input wire logic sweep_end,
    input wire logic step_done,
    output logic [ssc_pkg::SSC_CODE_W-1:0] step_code,
    output logic [ssc_pkg::SSC_IDX_W-1:0] seq_step,
    output logic running,
    output logic held,
    output logic restart
);
    import ssc_pkg::*;

    logic rst_meta_q;
    logic rst_n_q;
    ssc_req_s req;
    ssc_ctl_s ctl_q;
    logic [SSC_IDX_W-1:0] seq_last_q;
    logic [SSC_IDX_W-1:0] evt_dest_q;
    logic [7:0] step_mem_q [SSC_NUM_STEPS];
    logic [31:0] rdata_q;
    logic [SSC_IN_W-1:0] pins;
    logic [SSC_IN_W-1:0] lvl;
    logic [SSC_IN_W-1:0] fall;
    logic [SSC_IN_W-1:0] rise;
    ssc_state_e state_q;
    ssc_state_e state_d;
    logic [SSC_IDX_W-1:0] idx_q;
    logic [SSC_IDX_W-1:0] idx_d;
    logic restart_q;
    logic restart_d;
    logic running_q;
    logic held_q;
    logic [SSC_CODE_W-1:0] code_q;
    logic en;
    logic start_ev;
    logic stop_ev;
    logic hold_ev;
    logic resume_ev;
    logic event_ev;
    logic branch_low;
    logic step_sel;
    logic [7:0] cur_entry;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // bundle the register port
    assign req.addr = addr;
    assign req.wdata = wdata;
    assign req.wr = wr;
    assign req.rd = rd;

    // control, last step and event destination registers
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctl_q <= SSC_CTRL_RESET;
            seq_last_q <= SSC_SEQ_LAST_RESET;
            evt_dest_q <= SSC_EVT_DEST_RESET;
        end
        else if (req.wr)
        begin
            if (req.addr == SSC_ADDR_CTRL)
            begin
                ctl_q.seq_mode <= req.wdata[SSC_CTRL_MODE_BIT];
                ctl_q.ctrl_en <= req.wdata[SSC_CTRL_EN_BIT];
                ctl_q.start_is_branch <= req.wdata[SSC_CTRL_SEL_BIT];
            end
            if (req.addr == SSC_ADDR_SEQ_LAST)
            begin
                seq_last_q <= req.wdata[SSC_IDX_W-1:0];
            end
            if (req.addr == SSC_ADDR_EVT_DEST)
            begin
                evt_dest_q <= req.wdata[SSC_IDX_W-1:0];
            end
        end
    end

    // step table: code and state-branch destination per entry
    for (genvar i = 0; i < SSC_NUM_STEPS; i++)
    begin : g_step
        always_ff @(posedge ref_clk or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                step_mem_q[i] <= SSC_STEP_RESET;
            end
            else if (req.wr && req.addr == SSC_ADDR_STEP_BASE + 8'(4 * i))
            begin
                step_mem_q[i] <= req.wdata[7:0];
            end
        end
    end

    // read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= 32'h0000_0000;
            if (req.rd)
            begin
                if (req.addr == SSC_ADDR_CTRL)
                begin
                    rdata_q[2:0] <= ctl_q;
                end
                else if (req.addr == SSC_ADDR_STATUS)
                begin
                    rdata_q[1:0] <= state_q;
                    rdata_q[7:4] <= idx_q;
                    rdata_q[12:8] <= lvl;
                end
                else if (req.addr == SSC_ADDR_SEQ_LAST)
                begin
                    rdata_q[SSC_IDX_W-1:0] <= seq_last_q;
                end
                else if (req.addr == SSC_ADDR_EVT_DEST)
                begin
                    rdata_q[SSC_IDX_W-1:0] <= evt_dest_q;
                end
                else if (step_sel)
                begin
                    rdata_q[7:0] <= step_mem_q[req.addr[5:2]];
                end
            end
        end
    end

    // step table window decode
    assign step_sel = (req.addr[7:6] == SSC_ADDR_STEP_BASE[7:6]) && (req.addr[1:0] == 2'h0);

    // connector inputs into the clock domain
    assign pins = {external_trigger_input, ctl_event_n, ctl_hold_n, ctl_stop_n, ctl_start_n};

    ssc_sync #(
        .W(SSC_IN_W)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .din(pins),
        .level(lvl),
        .fall(fall),
        .rise(rise)
    );

    // qualified control events, lines except the trigger ignored while disabled
    assign en = ctl_q.ctrl_en;
    assign start_ev = rise[SSC_IN_TRIG]
        | (en & fall[SSC_IN_START] & ~(ctl_q.seq_mode & ctl_q.start_is_branch));
    assign stop_ev = en & fall[SSC_IN_STOP];
    assign hold_ev = en & fall[SSC_IN_HOLD];
    assign resume_ev = en & rise[SSC_IN_HOLD];
    assign event_ev = en & ctl_q.seq_mode & fall[SSC_IN_EVENT];
    assign branch_low = en & ctl_q.start_is_branch & ~lvl[SSC_IN_START];
    assign cur_entry = step_mem_q[idx_q];

    // run state and step index: stop > start > event > hold/resume > end
    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        restart_d = 1'b0;
        if (stop_ev)
        begin
            state_d = SSC_IDLE;
        end
        else if (start_ev)
        begin
            state_d = SSC_RUN;
            idx_d = '0;
            restart_d = 1'b1;
        end
        else if (event_ev && state_q != SSC_IDLE)
        begin
            idx_d = evt_dest_q;
            restart_d = 1'b1;
        end
        else
        begin
            case (state_q)
                SSC_RUN:
                begin
                    if (hold_ev)
                    begin
                        state_d = SSC_HOLD;
                    end
                    else if (!ctl_q.seq_mode && sweep_end)
                    begin
                        state_d = SSC_IDLE;
                    end
                    else if (ctl_q.seq_mode && step_done)
                    begin
                        if (branch_low)
                        begin
                            idx_d = cur_entry[SSC_STEP_DEST_LSB +: SSC_IDX_W];
                        end
                        else if (idx_q == seq_last_q)
                        begin
                            state_d = SSC_IDLE;
                        end
                        else
                        begin
                            idx_d = idx_q + 4'h1;
                        end
                    end
                end
                SSC_HOLD:
                begin
                    if (resume_ev)
                    begin
                        state_d = SSC_RUN;
                    end
                end
                SSC_IDLE:
                begin
                    state_d = SSC_IDLE;
                end
                default:
                begin
                    state_d = SSC_IDLE;
                end
            endcase
        end
    end

    // run state registers
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= SSC_IDLE;
            idx_q <= '0;
            restart_q <= 1'b0;
            running_q <= 1'b0;
            held_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            restart_q <= restart_d;
            running_q <= (state_d == SSC_RUN); // status flops track the next state
            held_q <= (state_d == SSC_HOLD);
        end
    end

    // step code of the running step, zero in sweep mode or idle
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            code_q <= '0;
        end
        else if (ctl_q.seq_mode && state_d != SSC_IDLE)
        begin
            code_q <= step_mem_q[idx_d][SSC_STEP_CODE_LSB +: SSC_CODE_W];
        end
        else
        begin
            code_q <= '0;
        end
    end

    // outputs straight from flops
    assign rdata = rdata_q;
    assign step_code = code_q; // bit 0 is step_code_bit_low
    assign seq_step = idx_q;
    assign running = running_q;
    assign held = held_q;
    assign restart = restart_q;
endmodule
`default_nettype wire

// File: ssc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_top_test;
    import ssc_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sweep_end = 1'b0;
    logic step_done = 1'b0;
    logic [4:0] pins;
    logic [31:0] rdata;
    logic [3:0] step_code;
    logic [3:0] seq_step;
    logic running, held, restart;
    int errors = 0;
    int compares = 0;
    always #5 ref_clk = ~ref_clk;
    ssc_far u_far (.clk(ref_clk), .pins(pins));
    ssc_top DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ctl_start_n(pins[SSC_IN_START]),
        .ctl_stop_n(pins[SSC_IN_STOP]), .ctl_hold_n(pins[SSC_IN_HOLD]),
        .ctl_event_n(pins[SSC_IN_EVENT]), .external_trigger_input(pins[SSC_IN_TRIG]),
        .sweep_end(sweep_end), .step_done(step_done), .step_code(step_code),
        .seq_step(seq_step), .running(running), .held(held), .restart(restart));
    task automatic tally_and_finish();
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // packed as running, held, step index, step code
    task automatic chk_out(input logic [9:0] exp);
        #1;
        chk({22'h0, running, held, seq_step, step_code}, {22'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // one finish pulse from the sweep or sequence engine
    task automatic engine(input logic sw);
        @(posedge ref_clk);
        sweep_end <= sw;
        step_done <= !sw;
        @(posedge ref_clk);
        sweep_end <= 1'b0;
        step_done <= 1'b0;
    endtask
    task automatic t_regs();
        rd_reg(SSC_ADDR_CTRL, 32'h0);
        wr_reg(SSC_ADDR_SEQ_LAST, 32'hFFFFFFF2);
        rd_reg(SSC_ADDR_SEQ_LAST, 32'h2);
        rd_reg(8'h10, 32'h0);
        rd_reg(SSC_ADDR_STATUS, 32'h1F00);
    endtask
    task automatic t_sweep();
        wr_reg(SSC_ADDR_CTRL, 32'h2);
        u_far.pulse(SSC_IN_START, 2);
        tick(5);
        chk_out(10'h200);
        u_far.set_line(SSC_IN_HOLD, 1'b0);
        tick(5);
        chk_out(10'h100);
        u_far.set_line(SSC_IN_HOLD, 1'b1);
        tick(5);
        chk_out(10'h200);
        u_far.pulse(SSC_IN_STOP, 2);
        tick(5);
        chk_out(10'h000);
        u_far.pulse(SSC_IN_TRIG, 3);
        tick(5);
        chk_out(10'h200);
        engine(1'b1);
        tick(2);
        chk_out(10'h000);
    endtask
    task automatic t_seq();
        wr_reg(SSC_ADDR_CTRL, 32'h3);
        wr_reg(SSC_ADDR_STEP_BASE, 32'h5);
        wr_reg(SSC_ADDR_STEP_BASE + 8'h04, 32'hA);
        wr_reg(SSC_ADDR_STEP_BASE + 8'h08, 32'h3);
        wr_reg(SSC_ADDR_EVT_DEST, 32'h2);
        rd_reg(SSC_ADDR_STEP_BASE + 8'h04, 32'hA);
        u_far.pulse(SSC_IN_START, 2);
        tick(5);
        chk_out(10'h205);
        engine(1'b0);
        tick(2);
        chk_out(10'h21A);
        u_far.set_line(SSC_IN_HOLD, 1'b0);
        tick(5);
        engine(1'b0);
        tick(2);
        chk_out(10'h11A);
        u_far.set_line(SSC_IN_HOLD, 1'b1);
        tick(5);
        chk_out(10'h21A);
        u_far.pulse(SSC_IN_EVENT, 2);
        tick(5);
        chk_out(10'h223);
        engine(1'b0);
        tick(2);
        chk_out(10'h020);
        u_far.pulse(SSC_IN_START, 2);
        u_far.pulse(SSC_IN_STOP, 2);
        tick(5);
        chk_out(10'h000);
    endtask
    task automatic t_branch();
        wr_reg(SSC_ADDR_CTRL, 32'h7);
        wr_reg(SSC_ADDR_STEP_BASE, 32'h35);
        wr_reg(SSC_ADDR_STEP_BASE + 8'h0C, 32'h9);
        wr_reg(SSC_ADDR_SEQ_LAST, 32'h3);
        u_far.pulse(SSC_IN_TRIG, 2);
        tick(5);
        chk_out(10'h205);
        u_far.set_line(SSC_IN_START, 1'b0);
        tick(5);
        chk_out(10'h205);
        engine(1'b0);
        tick(2);
        chk_out(10'h239);
        u_far.set_line(SSC_IN_START, 1'b1);
        tick(4);
        engine(1'b0);
        tick(2);
        chk_out(10'h030);
        wr_reg(SSC_ADDR_CTRL, 32'h1);
        u_far.pulse(SSC_IN_START, 2);
        tick(5);
        chk_out(10'h030);
    endtask
    // main sequence
    initial
    begin
        tick(12);
        resetn <= 1'b1;
        tick(3);
        t_regs();
        t_sweep();
        t_seq();
        t_branch();
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        #50us;
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
